// ===== rtl/cmf_mac.sv
// CSMA/CD framing: preamble generation, attempt/jam state, receive
// delimiting, fragment filtering, octet truncation and status.
// Assumes a deference block drives deferring_i and consumes the gap parts.
`timescale 1ns/1ps
`default_nettype none
module cmf_mac #(
	parameter int IFS_BITS = 96
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            carrier_sense_i,
	input  wire logic            collision_detect_i,
	input  wire logic            rx_bit_i,
	output logic                 tx_bit_o,
	output logic                 tx_en_o,
	input  wire logic            deferring_i,
	output logic                 frame_waiting_o,
	output logic      [6:0]      ifs_part1_o,
	output logic      [6:0]      ifs_part2_o,
	input  wire logic            tx_req_i,
	input  wire logic            tx_bit_i,
	input  wire logic            tx_last_i,
	output logic                 tx_take_o,
	output cmf_pkg::cmf_tx_t     tx_o,
	output cmf_pkg::cmf_rx_t     rx_o
);
	localparam logic [6:0] IFS_W  = 7'(IFS_BITS);
	localparam logic [6:0] IFS1_MAX = 7'((IFS_BITS * 2) / 3);

	if (IFS_BITS < 3 || IFS_BITS > 127) begin : g_chk
		$error("IFS_BITS must lie in 3..127");
	end

	typedef struct packed {
		cmf_pkg::cmf_tx_st_t tx_st;
		logic [7:0]          tx_cnt;
		logic [4:0]          attempts;
		logic                new_coll;
		logic                tx_bit;
		logic                tx_en;
		cmf_pkg::cmf_tx_t    tx;
		cmf_pkg::cmf_rx_st_t rx_st;
		logic [7:0]          sh;
		logic [7:0]          oct;
		logic [15:0]         bitcnt;
		logic [10:0]         octcnt;
		logic [31:0]         crc;
		logic [31:0]         crc_oct;
		logic                oversize;
		cmf_pkg::cmf_rx_t    rx;
		logic [1:0]          last_st;
		logic [4:0]          att_lim;
		logic [7:0]          jam_len;
		logic [6:0]          ifs1;
		logic [10:0]         max_oct;
		logic [9:0]          min_bits;
		logic                ack;
		logic [31:0]         rdata;
	} cmf_state_t;

	cmf_state_t s_ff;
	cmf_state_t nxt_s;
	logic [31:0] rd_word;
	logic [6:0]  ifs2;

	assign ifs2 = IFS_W - s_ff.ifs1; // see RQ12

	always_comb begin
		rd_word = 32'h00000000;
		case (wb_adr_i)
			cmf_pkg::ADR_CFG_TX: begin
				rd_word = {9'h000, s_ff.ifs1, s_ff.jam_len, 3'h0, s_ff.att_lim};
			end
			cmf_pkg::ADR_CFG_RX: begin
				rd_word = {6'h00, s_ff.min_bits, 5'h00, s_ff.max_oct};
			end
			cmf_pkg::ADR_STATUS: begin
				rd_word = {20'h00000,
				           (s_ff.tx_st != cmf_pkg::CMF_TX_IDLE),
				           (s_ff.rx_st != cmf_pkg::CMF_RX_IDLE),
				           s_ff.last_st, 1'b0,
				           (s_ff.tx_st == cmf_pkg::CMF_TX_WAIT),
				           s_ff.new_coll, s_ff.attempts};
			end
			cmf_pkg::ADR_IFS: begin
				rd_word = {17'h00000, ifs2, 1'b0, s_ff.ifs1};
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		logic [31:0] crc_n;
		logic [7:0]  oct_n;
		logic [7:0]  sh_n;
		logic [1:0]  st_n;
		crc_n = cmf_pkg::cmf_crc_step(s_ff.crc, rx_bit_i);
		oct_n = {rx_bit_i, s_ff.oct[7:1]};
		sh_n  = {s_ff.sh[6:0], rx_bit_i};
		st_n  = cmf_pkg::RX_OK;
		nxt_s = s_ff;
		nxt_s.ack      = 1'b0;
		nxt_s.tx.done  = 1'b0;
		nxt_s.tx.retry = 1'b0;
		nxt_s.rx.valid = 1'b0;
		nxt_s.rx.done  = 1'b0;
		nxt_s.rx.drop  = 1'b0;
		nxt_s.tx_en    = 1'b0;
		nxt_s.tx_bit   = 1'b0;

		// bus slave: one wait state, unmapped reads zero
		if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
			nxt_s.ack   = 1'b1;
			nxt_s.rdata = rd_word;
			if (wb_we_i && wb_adr_i == cmf_pkg::ADR_CFG_TX) begin
				if (wb_sel_i[0]) begin
					nxt_s.att_lim = (wb_dat_i[4:0] == 5'h00) ? 5'h01
					                                         : wb_dat_i[4:0];
				end
				if (wb_sel_i[1]) begin // see RQ16
					nxt_s.jam_len = (wb_dat_i[15:8] == 8'h00) ? 8'h01
					                                          : wb_dat_i[15:8];
				end
				if (wb_sel_i[2]) begin // see RQ12
					nxt_s.ifs1 = (wb_dat_i[22:16] > IFS1_MAX) ? IFS1_MAX
					                                          : wb_dat_i[22:16];
				end
			end
			if (wb_we_i && wb_adr_i == cmf_pkg::ADR_CFG_RX) begin
				if (wb_sel_i[0]) begin
					nxt_s.max_oct[7:0] = wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					nxt_s.max_oct[10:8] = wb_dat_i[10:8];
				end
				if (wb_sel_i[2]) begin
					nxt_s.min_bits[7:0] = wb_dat_i[23:16];
				end
				if (wb_sel_i[3]) begin
					nxt_s.min_bits[9:8] = wb_dat_i[25:24];
				end
			end
		end

		case (s_ff.tx_st)
			cmf_pkg::CMF_TX_IDLE: begin
				if (tx_req_i) begin
					nxt_s.tx_st    = cmf_pkg::CMF_TX_WAIT;
					nxt_s.attempts = 5'h00;
				end
			end
			cmf_pkg::CMF_TX_WAIT: begin
				if (!deferring_i) begin // see RQ17
					nxt_s.tx_st  = cmf_pkg::CMF_TX_PRE;
					nxt_s.tx_cnt = 8'h00;
				end
			end
			cmf_pkg::CMF_TX_PRE: begin
				nxt_s.tx_en  = 1'b1;
				nxt_s.tx_bit = cmf_pkg::PRE_PATTERN[3'h7 - s_ff.tx_cnt[2:0]]; // see RQ9
				nxt_s.tx_cnt = s_ff.tx_cnt + 8'h01;
				if (collision_detect_i) begin
					nxt_s.new_coll = 1'b1; // see RQ15
				end
				// a collision here only takes effect once the preamble is out
				if (s_ff.tx_cnt == 8'(cmf_pkg::PRE_BITS - 1)) begin // see RQ8
					nxt_s.tx_cnt = 8'h00;
					nxt_s.tx_st  = (s_ff.new_coll || collision_detect_i)
					             ? cmf_pkg::CMF_TX_JAM : cmf_pkg::CMF_TX_SFD; // see RQ7
				end
			end
			cmf_pkg::CMF_TX_SFD: begin
				nxt_s.tx_en  = 1'b1;
				nxt_s.tx_bit = cmf_pkg::SFD_PATTERN[3'h7 - s_ff.tx_cnt[2:0]];
				nxt_s.tx_cnt = s_ff.tx_cnt + 8'h01;
				if (collision_detect_i) begin
					nxt_s.new_coll = 1'b1;
					nxt_s.tx_cnt   = 8'h00;
					nxt_s.tx_st    = cmf_pkg::CMF_TX_JAM;
				end else if (s_ff.tx_cnt == 8'(cmf_pkg::SFD_BITS - 1)) begin // see RQ11
					nxt_s.tx_st = cmf_pkg::CMF_TX_DATA;
				end
			end
			cmf_pkg::CMF_TX_DATA: begin
				nxt_s.tx_en  = 1'b1;
				nxt_s.tx_bit = tx_bit_i; // see RQ13
				if (collision_detect_i) begin
					nxt_s.new_coll = 1'b1; // see RQ15
					nxt_s.tx_cnt   = 8'h00;
					nxt_s.tx_st    = cmf_pkg::CMF_TX_JAM;
				end else if (tx_last_i) begin
					nxt_s.tx_st     = cmf_pkg::CMF_TX_DONE;
					nxt_s.tx.done   = 1'b1;
					nxt_s.tx.status = cmf_pkg::TX_OK;
					nxt_s.attempts  = s_ff.attempts + 5'h01;
				end
			end
			cmf_pkg::CMF_TX_JAM: begin
				nxt_s.tx_en  = 1'b1;
				nxt_s.tx_bit = cmf_pkg::JAM_BIT;
				nxt_s.tx_cnt = s_ff.tx_cnt + 8'h01;
				if (s_ff.tx_cnt == s_ff.jam_len - 8'h01) begin // see RQ16
					nxt_s.new_coll = 1'b0; // see RQ15
					nxt_s.attempts = s_ff.attempts + 5'h01; // see RQ14
					if (s_ff.attempts + 5'h01 >= s_ff.att_lim) begin
						nxt_s.tx_st     = cmf_pkg::CMF_TX_DONE;
						nxt_s.tx.done   = 1'b1;
						nxt_s.tx.status = cmf_pkg::TX_EXCESS;
					end else begin
						nxt_s.tx.retry = 1'b1;
						nxt_s.tx_st    = cmf_pkg::CMF_TX_WAIT;
					end
				end
			end
			cmf_pkg::CMF_TX_DONE: begin
				if (!tx_req_i) begin
					nxt_s.tx_st = cmf_pkg::CMF_TX_IDLE;
				end
			end
			default: begin
				nxt_s.tx_st = cmf_pkg::CMF_TX_IDLE;
			end
		endcase

		case (s_ff.rx_st)
			cmf_pkg::CMF_RX_IDLE: begin
				if (carrier_sense_i) begin // see RQ1
					nxt_s.rx_st = cmf_pkg::CMF_RX_HUNT;
					nxt_s.sh    = 8'h00;
				end
			end
			cmf_pkg::CMF_RX_HUNT: begin
				nxt_s.sh = sh_n;
				if (!carrier_sense_i) begin
					nxt_s.rx_st = cmf_pkg::CMF_RX_IDLE;
				end else if (sh_n == cmf_pkg::SFD_PATTERN) begin // see RQ10
					nxt_s.rx_st    = cmf_pkg::CMF_RX_DATA;
					nxt_s.crc      = cmf_pkg::CRC_INIT;
					nxt_s.crc_oct  = cmf_pkg::CRC_INIT;
					nxt_s.bitcnt   = 16'h0000;
					nxt_s.octcnt   = 11'h000;
					nxt_s.oversize = 1'b0;
				end
			end
			cmf_pkg::CMF_RX_DATA: begin
				if (carrier_sense_i) begin
					nxt_s.crc = crc_n; // see RQ19
					nxt_s.oct = oct_n;
					// saturate rather than wrap on endless carrier
					if (s_ff.bitcnt != 16'hFFFF) begin
						nxt_s.bitcnt = s_ff.bitcnt + 16'h0001;
					end
					if (s_ff.bitcnt[2:0] == 3'h7 && !s_ff.oversize) begin
						if (s_ff.max_oct != 11'h000
						    && s_ff.octcnt == s_ff.max_oct) begin
							nxt_s.oversize = 1'b1; // see RQ2
						end else begin
							nxt_s.rx.valid = 1'b1; // see RQ13
							nxt_s.rx.data  = oct_n;
							nxt_s.rx.idx   = s_ff.octcnt;
							nxt_s.octcnt   = s_ff.octcnt + 11'h001;
							nxt_s.crc_oct  = crc_n; // see RQ3
						end
					end
				end else begin
					nxt_s.rx_st = cmf_pkg::CMF_RX_IDLE; // see RQ1
					if (s_ff.bitcnt < {6'h00, s_ff.min_bits}) begin // see RQ5
						nxt_s.rx.drop = 1'b1; // see RQ6
					end else begin
						if (s_ff.oversize) begin
							st_n = cmf_pkg::RX_LEN_ERR;
						end else if (s_ff.crc_oct != cmf_pkg::CRC_RESIDUE) begin
							st_n = (s_ff.bitcnt[2:0] != 3'h0)
							     ? cmf_pkg::RX_ALIGN_ERR // see RQ4
							     : cmf_pkg::RX_FCS_ERR; // see RQ19
						end
						nxt_s.rx.done   = 1'b1; // see RQ20
						nxt_s.rx.status = st_n;
						nxt_s.last_st   = st_n;
					end
				end
			end
			default: begin
				nxt_s.rx_st = cmf_pkg::CMF_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_ff          <= '0;
			s_ff.att_lim  <= cmf_pkg::ATT_LIM_RST;
			s_ff.jam_len  <= cmf_pkg::JAM_LEN_RST;
			s_ff.ifs1     <= cmf_pkg::IFS1_RST;
			s_ff.max_oct  <= cmf_pkg::MAX_OCT_RST;
			s_ff.min_bits <= cmf_pkg::MIN_BITS_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign wb_ack_o        = s_ff.ack;
	assign wb_dat_o        = s_ff.rdata;
	assign tx_bit_o        = s_ff.tx_bit;
	assign tx_en_o         = s_ff.tx_en;
	assign frame_waiting_o = (s_ff.tx_st == cmf_pkg::CMF_TX_WAIT); // see RQ18
	assign ifs_part1_o     = s_ff.ifs1;
	assign ifs_part2_o     = ifs2;
	assign tx_take_o       = (s_ff.tx_st == cmf_pkg::CMF_TX_DATA)
	                       && !collision_detect_i;
	assign tx_o            = s_ff.tx;
	assign rx_o            = s_ff.rx;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged next cycle");
	pre_full_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_PRE // see RQ8
		&& s_ff.tx_cnt != 8'(cmf_pkg::PRE_BITS - 1) |=> s_ff.tx_st == cmf_pkg::CMF_TX_PRE)
		else $error("preamble cut short");
	pre_bits_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_PRE // see RQ9
		|=> tx_en_o && tx_bit_o == !$past(s_ff.tx_cnt[0]))
		else $error("wrong preamble bit");
	sfd_len_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_SFD // see RQ11
		&& !collision_detect_i && s_ff.tx_cnt != 8'h07
		|=> s_ff.tx_st == cmf_pkg::CMF_TX_SFD)
		else $error("delimiter not eight bits");
	defer_hold_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_WAIT // see RQ17
		&& deferring_i |=> frame_waiting_o && !tx_en_o)
		else $error("transmission started while deferring");
	coll_flag_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_DATA // see RQ15
		&& collision_detect_i |=> s_ff.new_coll && s_ff.tx_st == cmf_pkg::CMF_TX_JAM)
		else $error("collision not flagged for jam");
	att_range_a: assert property (s_ff.attempts <= s_ff.att_lim) // see RQ14
		else $error("attempt counter above limit");
	frag_drop_a: assert property (s_ff.rx_st == cmf_pkg::CMF_RX_DATA // see RQ6
		&& !carrier_sense_i && s_ff.bitcnt < {6'h00, s_ff.min_bits}
		|=> rx_o.drop && !rx_o.done)
		else $error("fragment not silently dropped");
	align_err_a: assert property (s_ff.rx_st == cmf_pkg::CMF_RX_DATA // see RQ4
		&& !carrier_sense_i && !s_ff.oversize && s_ff.bitcnt[2:0] != 3'h0
		&& s_ff.bitcnt >= {6'h00, s_ff.min_bits}
		&& s_ff.crc_oct != cmf_pkg::CRC_RESIDUE
		|=> rx_o.done && rx_o.status == cmf_pkg::RX_ALIGN_ERR)
		else $error("alignment error not reported");
	ifs_split_a: assert property (ifs_part1_o <= IFS1_MAX // see RQ12
		&& ifs_part1_o + ifs_part2_o == IFS_W)
		else $error("gap parts do not add up");
	jam_bits_a: assert property (s_ff.tx_st == cmf_pkg::CMF_TX_JAM // see RQ16
		|=> tx_en_o && tx_bit_o == cmf_pkg::JAM_BIT)
		else $error("jam bit missing or wrong");
	rx_gate_a: assert property (s_ff.rx_st != cmf_pkg::CMF_RX_DATA // see RQ10
		|=> !rx_o.valid)
		else $error("octet delivered before delimiter");
	rx_status_a: assert property (rx_o.done // see RQ20
		|-> !rx_o.drop && !rx_o.valid)
		else $error("frame ended with conflicting outcome");
endmodule
`default_nettype wire

// ===== rtl/cmf_pkg.sv
// Constants, types and helpers for the CSMA/CD framing block.
// Assumes one bit per clock on both the transmit and receive paths.
// Contract
// RQ1 - carrier sense bounds each received frame
// RQ2 - optional cut-off above maximum octet count
// RQ3 - drop trailing partial octet on receive
// RQ4 - truncated frame with bad check: alignment error
// RQ5 - minimum frame bits set fragment threshold
// RQ6 - short frames discarded silently as fragments
// RQ7 - preamble then delimiter before frame bits
// RQ8 - collision never shortens the preamble
// RQ9 - preamble is seven 10101010 octets
// RQ10 - receive only after delimiter 10101011 seen
// RQ11 - delimiter eight bits, header is sum
// RQ12 - gap part one up to two thirds
// RQ13 - frame fields in order, flat bit view
// RQ14 - attempt counter up to attempt limit
// RQ15 - collision flag held until jam sent
// RQ16 - jam length in bits is configurable
// RQ17 - deferring holds off pending transmission
// RQ18 - frame waiting shown while deferred
// RQ19 - recompute check sequence, flag mismatch
// RQ20 - one completion status per delivered frame
package cmf_pkg;
	localparam int          PRE_OCTETS   = 7;
	localparam int          PRE_BITS     = PRE_OCTETS * 8;
	localparam int          SFD_BITS     = 8;
	localparam int          HDR_BITS     = PRE_BITS + SFD_BITS;
	localparam logic [7:0]  PRE_PATTERN  = 8'hAA;
	localparam logic [7:0]  SFD_PATTERN  = 8'hAB;
	localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
	localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB20E3;
	localparam logic        JAM_BIT      = 1'b1;

	localparam logic [7:0]  ADR_CFG_TX   = 8'h00;
	localparam logic [7:0]  ADR_CFG_RX   = 8'h04;
	localparam logic [7:0]  ADR_STATUS   = 8'h08;
	localparam logic [7:0]  ADR_IFS      = 8'h0C;

	localparam logic [4:0]  ATT_LIM_RST  = 5'h10;
	localparam logic [7:0]  JAM_LEN_RST  = 8'h20;
	localparam logic [6:0]  IFS1_RST     = 7'h40;
	localparam logic [10:0] MAX_OCT_RST  = 11'h5EE;
	localparam logic [9:0]  MIN_BITS_RST = 10'h200;

	localparam logic [1:0]  RX_OK        = 2'h0;
	localparam logic [1:0]  RX_LEN_ERR   = 2'h1;
	localparam logic [1:0]  RX_FCS_ERR   = 2'h2;
	localparam logic [1:0]  RX_ALIGN_ERR = 2'h3;
	localparam logic        TX_OK        = 1'b0;
	localparam logic        TX_EXCESS    = 1'b1;

	typedef enum logic [2:0] {
		CMF_TX_IDLE, CMF_TX_WAIT, CMF_TX_PRE, CMF_TX_SFD,
		CMF_TX_DATA, CMF_TX_JAM, CMF_TX_DONE
	} cmf_tx_st_t;

	typedef enum logic [1:0] {
		CMF_RX_IDLE, CMF_RX_HUNT, CMF_RX_DATA
	} cmf_rx_st_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  data;
		logic [10:0] idx;
		logic        done;
		logic        drop;
		logic [1:0]  status;
	} cmf_rx_t;

	typedef struct packed {
		logic        done;
		logic        status;
		logic        retry;
	} cmf_tx_t;

	function automatic logic [31:0] cmf_crc_step(input logic [31:0] c,
	                                             input logic        b);
		cmf_crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 32'h00000000);
	endfunction
endpackage

// ===== tb/cmf_partner.sv
// Far-side model: client transmit bit stream and line receive source.
// Assumes the bench calls load and send; drives follow rising edges.
`timescale 1ns/1ps
`default_nettype none
module cmf_partner (
	input  wire logic clk_i,
	input  wire logic take_i,
	input  wire logic retry_i,
	output logic      bit_o,
	output logic      last_o,
	output logic      cs_o,
	output logic      line_o
);
	logic q[$];
	int   ptr;
	initial begin
		bit_o = 1'b0;
		last_o = 1'b0;
		cs_o = 1'b0;
		line_o = 1'b0;
		ptr = 0;
	end
	task automatic load(input logic [15:0] v);
		q.delete();
		for (int i = 0; i < 16; i++)
			q.push_back(v[i]);
		ptr = 0;
	endtask
	// client restarts the stream from its first bit on a retry
	always @(posedge clk_i) begin
		if (retry_i === 1'b1)
			ptr = 0;
		else if (take_i === 1'b1)
			ptr = ptr + 1;
		bit_o  <= q[ptr];
		last_o <= (ptr == q.size() - 1);
	end
	// frame body goes out behind seven preamble octets and the delimiter
	task automatic send(input logic b[$]);
		logic f[$];
		logic last;
		for (int i = 0; i < 62; i++)
			f.push_back(~i[0]);
		f.push_back(1'b1);
		f.push_back(1'b1);
		f = {f, b};
		foreach (f[i]) begin
			@(posedge clk_i);
			cs_o <= 1'b1;
			line_o <= f[i];
			last = f[i];
		end
		@(posedge clk_i);
		cs_o <= 1'b0;
		line_o <= ~last;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Bench for the framing block: register, transmit and receive sequences.
// Assumes cmf_partner stands in for the client and the line.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]       wb_adr_i;
	logic [3:0]       wb_sel_i;
	logic [31:0]      wb_dat_i, wb_dat_o, q;
	logic             carrier_sense_i, collision_detect_i, rx_bit_i;
	logic             tx_bit_o, tx_en_o, deferring_i, frame_waiting_o;
	logic [6:0]       ifs_part1_o, ifs_part2_o;
	logic             tx_req_i, tx_bit_i, tx_last_i, tx_take_o, tx_st;
	logic [1:0]       rx_st;
	cmf_pkg::cmf_tx_t tx_o;
	cmf_pkg::cmf_rx_t rx_o;
	logic             txl[$];
	logic [7:0]       rxq[$];
	int               mismatches, check_count, cycles;
	int               n_done, n_drop, tx_fin, n_retry;
	cmf_mac dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .carrier_sense_i,
		.collision_detect_i, .rx_bit_i, .tx_bit_o, .tx_en_o, .deferring_i,
		.frame_waiting_o, .ifs_part1_o, .ifs_part2_o, .tx_req_i, .tx_bit_i,
		.tx_last_i, .tx_take_o, .tx_o, .rx_o);
	cmf_partner p (.clk_i, .take_i(tx_take_o), .retry_i(tx_o.retry),
		.bit_o(tx_bit_i), .last_o(tx_last_i), .cs_o(carrier_sense_i),
		.line_o(rx_bit_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, e);
		wb(1'b0, a, 32'h00000000);
		check(n, q & m, e);
	endtask
	function automatic logic hb(input int i);
		logic [15:0] w;
		w = 16'hC35A;
		return (i < 62) ? ~i[0] : (i < 64) ? 1'b1 : w[i - 64];
	endfunction
	function automatic logic [31:0] fcs(input logic b[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (b[i])
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? 32'hEDB88320 : 32'h00000000);
		return ~c;
	endfunction
	task automatic rxf(input int n, bad, extra, en, ed, input logic [1:0] es);
		logic        b[$];
		logic [31:0] f;
		logic [7:0]  e;
		rxq.delete();
		n_done = 0;
		n_drop = 0;
		for (int i = 0; i < n * 8; i++)
			b.push_back(i[1] ^ i[4]);
		f = fcs(b);
		for (int i = 0; i < 32; i++)
			b.push_back(f[i] ^ (bad != 0 && i == 0));
		repeat (extra) b.push_back(1'b1);
		p.send(b);
		repeat (4) @(posedge clk_i);
		check("rx octets", rxq.size(), en);
		check("rx done", n_done, ed);
		check("rx drop", n_drop, 1 - ed);
		if (ed != 0)
			check("rx status", rx_st, es);
		foreach (rxq[k]) begin
			for (int j = 0; j < 8; j++)
				e[j] = b[8 * k + j];
			check("rx data", rxq[k], e);
		end
		$display("test rx frame done");
	endtask
	// sampled mid-cycle: each registered pulse seen once, and no race
	// with the stimulus that moves on the rising edge
	always @(negedge clk_i) begin
		cycles++;
		if (tx_en_o === 1'b1)
			txl.push_back(tx_bit_o);
		if (rx_o.valid === 1'b1) begin
			check("rx idx", {21'h0, rx_o.idx}, rxq.size());
			rxq.push_back(rx_o.data);
		end
		if (rx_o.done === 1'b1) begin
			n_done++;
			rx_st = rx_o.status;
		end
		if (rx_o.drop === 1'b1)
			n_drop++;
		if (tx_o.done === 1'b1) begin
			tx_fin++;
			tx_st = tx_o.status;
		end
		if (tx_o.retry === 1'b1)
			n_retry++;
		if (cycles > 8000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		{mismatches, check_count, cycles, tx_fin, n_retry} = '0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		{collision_detect_i, deferring_i, tx_req_i} = '0;
		wb_sel_i = 4'hF;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd("cfg tx", cmf_pkg::ADR_CFG_TX, '1, 32'h00402010);
		rd("cfg rx", cmf_pkg::ADR_CFG_RX, '1, 32'h020005EE);
		rd("ifs", cmf_pkg::ADR_IFS, '1, 32'h00002040);
		rd("unmapped", 8'h10, '1, 32'h00000000);
		wb(1'b1, cmf_pkg::ADR_CFG_TX, 32'h007F0502);
		rd("ifs clamp", cmf_pkg::ADR_IFS, '1, 32'h00002040);
		wb(1'b1, cmf_pkg::ADR_CFG_TX, 32'h00000502);
		rd("ifs zero", cmf_pkg::ADR_IFS, '1, 32'h00006000);
		check("ifs port", {25'h0, ifs_part2_o}, 32'h00000060);
		check("ifs part1", {25'h0, ifs_part1_o}, 32'h00000000);
		$display("test registers done");
		p.load(16'hC35A);
		deferring_i <= 1'b1;
		tx_req_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		check("waiting", frame_waiting_o, 1'b1);
		check("held off", txl.size(), 0);
		deferring_i <= 1'b0;
		while (tx_fin == 0) @(posedge clk_i);
		tx_req_i <= 1'b0;
		check("tx length", txl.size(), 80);
		for (int i = 0; i < 80; i++)
			check("tx bit", txl[i], hb(i));
		check("tx ok", tx_st, cmf_pkg::TX_OK);
		rd("attempts", cmf_pkg::ADR_STATUS, 32'h0000001F, 32'h00000001);
		$display("test transmit done");
		p.load(16'hC35A);
		txl.delete();
		tx_req_i <= 1'b1;
		while (txl.size() < 10) @(posedge clk_i);
		collision_detect_i <= 1'b1;
		@(posedge clk_i);
		collision_detect_i <= 1'b0;
		rd("collision flag", cmf_pkg::ADR_STATUS, 32'h00000020, 32'h00000020);
		while (n_retry == 0) @(posedge clk_i);
		@(posedge clk_i);
		check("pre and jam", txl.size(), 61);
		for (int i = 0; i < 61; i++)
			check("jam bit", txl[i], hb(i) | (i >= 56));
		txl.delete();
		rd("flag cleared", cmf_pkg::ADR_STATUS, 32'h0000003F, 32'h00000001);
		while (txl.size() < 70) @(posedge clk_i);
		collision_detect_i <= 1'b1;
		@(posedge clk_i);
		collision_detect_i <= 1'b0;
		while (tx_fin == 1) @(posedge clk_i);
		tx_req_i <= 1'b0;
		check("excess", tx_st, cmf_pkg::TX_EXCESS);
		check("retries", n_retry, 1);
		check("cut short", txl.size() < 78, 1'b1);
		for (int i = 0; i < txl.size(); i++)
			check("jam tail", txl[i], i >= txl.size() - 5 ? 1'b1 :
				hb(i));
		$display("test collisions done");
		wb(1'b1, cmf_pkg::ADR_CFG_RX, 32'h00300000);
		rd("min bits", cmf_pkg::ADR_CFG_RX, '1, 32'h00300000);
		rxf(2, 0, 0, 6, 1, cmf_pkg::RX_OK);
		rxf(2, 1, 0, 6, 1, cmf_pkg::RX_FCS_ERR);
		rxf(2, 1, 3, 6, 1, cmf_pkg::RX_ALIGN_ERR);
		rxf(1, 0, 0, 5, 0, cmf_pkg::RX_OK);
		wb(1'b1, cmf_pkg::ADR_CFG_RX, 32'h00300004);
		rxf(4, 0, 0, 4, 1, cmf_pkg::RX_LEN_ERR);
		report_and_stop();
	end
endmodule
`default_nettype wire
